// file: core/dapc_pkg.sv
/*
  package for the dual-channel address map and power control block:
  geometry codes, host address bit positions, mapped request and DIMM
  control structs, clock pair counts.
  assumes a single 40 MHz clock domain and no software registers.
*/
// Contract
// - symmetric dual channel uses this map
// - six geometries with listed row/column/bank counts
// - columns from bits 3-5,7-13; x16-256 b1
// - four-bank banks from 14,15; 256x16 r12
// - eight-bank banks from 16,15,14; else r11
// - rows r0-r10 from 17-27, r12 from 28
// - three clock pairs per DIMM, six total
// - suspend flushes pending cycles before self refresh
// - CKE held low during suspend
// - ODT driven from configuration and target rank
package dapc_pkg;

  // device geometries, one per supported part
  typedef enum logic [2:0] {
    DAPC_G256X8,
    DAPC_G256X16,
    DAPC_G512X8,
    DAPC_G512X16,
    DAPC_G1GX8,
    DAPC_G1GX16
  } dapc_geom_type;

  localparam int DAPC_HOST_W = 33;
  localparam int DAPC_ROW_W = 14;
  localparam int DAPC_COL_W = 10;
  localparam int DAPC_BANK_W = 3;
  localparam int DAPC_CHAN_BIT = 6;
  localparam int DAPC_COL_LO = 3;
  localparam int DAPC_COL_MID = 7;
  localparam int DAPC_COL_TOP = 13;
  localparam int DAPC_BANK_LO = 14;
  localparam int DAPC_BANK_HI = 15;
  localparam int DAPC_BANK_X = 16;
  localparam int DAPC_ROW_LO = 17;
  localparam int DAPC_ROW_R12 = 28;
  localparam int DAPC_ROW_R11_8B = 29;
  localparam int DAPC_ROW_R13_512 = 29;
  localparam int DAPC_ROW_R13_1G = 30;
  localparam int DAPC_CLK_PER_DIMM = 3;
  localparam int DAPC_NUM_CHAN = 2;
  localparam int DAPC_RANKS_PER_DIMM = 2;

  // one translated DRAM address
  typedef struct packed {
    logic chan;
    logic [DAPC_BANK_W-1:0] bank;
    logic [DAPC_ROW_W-1:0] row;
    logic [DAPC_COL_W-1:0] col;
    logic out_of_range;
  } dapc_addr_type;

  // per-rank control toward the DIMMs
  typedef struct packed {
    logic [DAPC_NUM_CHAN*DAPC_RANKS_PER_DIMM-1:0] cke;
    logic [DAPC_NUM_CHAN*DAPC_RANKS_PER_DIMM-1:0] odt;
  } dapc_rank_ctl_type;

endpackage

// file: core/dapc_addr_map.sv
/*
  combinational host to DRAM address translation for symmetric
  dual-channel mode.
  assumes a stable geometry code and a host address in the same cycle.
*/
`timescale 1ns/1ps
module dapc_addr_map (
  // configuration
  input wire dapc_pkg::dapc_geom_type geom,
  // host address in, translated address out
  input wire logic [dapc_pkg::DAPC_HOST_W-1:0] host_addr,
  output dapc_pkg::dapc_addr_type mapped
);
  import dapc_pkg::*;

  // geometry class decodes
  wire is_8bank = (geom == DAPC_G1GX8) || (geom == DAPC_G1GX16);
  wire is_256x16 = (geom == DAPC_G256X16);
  wire has_r13 = (geom == DAPC_G512X8) || (geom == DAPC_G1GX8);
  wire has_r12 = !is_256x16;

  // highest host bit used per geometry; anything above is outside memory
  wire [5:0] top_bit = (geom == DAPC_G1GX8) ? 6'h1e :
                       (geom == DAPC_G1GX16) ? 6'h1d :
                       (geom == DAPC_G512X8) ? 6'h1d :
                       is_256x16 ? 6'h1b : 6'h1c;
  wire [DAPC_HOST_W-1:0] hi_mask = ~((33'h2 << top_bit) - 33'h1);

  // column: c0-c2 from 3-5, c3-c8 from 7-12; bit 6 skipped
  wire [DAPC_COL_W-1:0] col = {
    is_256x16 ? 1'b0 : host_addr[DAPC_COL_TOP],
    host_addr[DAPC_COL_MID +: 6],
    host_addr[DAPC_COL_LO +: 3]};

  // bank selection differs between four and eight bank parts
  wire [DAPC_BANK_W-1:0] bank = is_8bank ?
    {host_addr[DAPC_BANK_LO], host_addr[DAPC_BANK_HI],
     host_addr[DAPC_BANK_X]} :
    {1'b0,
     is_256x16 ? host_addr[DAPC_COL_TOP] : host_addr[DAPC_BANK_HI],
     host_addr[DAPC_BANK_LO]};

  // row assembly
  wire r11 = is_8bank ? host_addr[DAPC_ROW_R11_8B] :
             host_addr[DAPC_BANK_X];
  wire r12 = has_r12 ? host_addr[DAPC_ROW_R12] :
             host_addr[DAPC_BANK_HI];
  wire r13 = !has_r13 ? 1'b0 :
             (geom == DAPC_G1GX8) ? host_addr[DAPC_ROW_R13_1G] :
             host_addr[DAPC_ROW_R13_512];
  wire [DAPC_ROW_W-1:0] row = {r13, r12, r11,
    host_addr[DAPC_ROW_LO +: 11]};

  // bit 6 only picks the channel, never an address line
  assign mapped.chan = host_addr[DAPC_CHAN_BIT];
  assign mapped.col = col;
  assign mapped.bank = bank;
  assign mapped.row = row;
  assign mapped.out_of_range = |(host_addr & hi_mask);

endmodule // dapc_addr_map

// file: core/dapc_ctl.sv
/*
  top of the dual-channel address map and power control block:
  registers translated requests, runs the suspend-to-RAM entry
  sequence, drives CKE, ODT and the DIMM clock pairs.
  assumes the scheduler reports outstanding cycles on pending and
  accepts one request per valid/ready handshake.
*/
`timescale 1ns/1ps
module dapc_ctl #(
  parameter int CLK_PAIRS = dapc_pkg::DAPC_CLK_PER_DIMM,
  parameter int NUM_CHAN = dapc_pkg::DAPC_NUM_CHAN,
  parameter int RANKS = dapc_pkg::DAPC_RANKS_PER_DIMM
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // configuration
  input wire dapc_pkg::dapc_geom_type geom,
  input wire logic dual_symmetric,
  input wire logic [NUM_CHAN*RANKS-1:0] rank_present,
  // host request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [dapc_pkg::DAPC_HOST_W-1:0] req_addr,
  input wire logic [$clog2(RANKS)-1:0] req_rank,
  output logic req_ready,
  // translated request toward the scheduler
  output logic map_valid,
  output logic map_write,
  output dapc_pkg::dapc_addr_type map_addr,
  output logic [$clog2(RANKS)-1:0] map_rank,
  // scheduler status
  input wire logic pending,
  input wire logic xfer_active,
  // power management
  input wire logic suspend_req,
  output logic self_refresh_cmd,
  output logic suspend_to_ram_state,
  // DIMM pins
  output logic [NUM_CHAN*CLK_PAIRS-1:0] dimm_clk_p,
  output logic [NUM_CHAN*CLK_PAIRS-1:0] dimm_clk_n,
  output logic [NUM_CHAN*RANKS-1:0] cke,
  output logic [NUM_CHAN*RANKS-1:0] odt
);
  import dapc_pkg::*;

  typedef enum logic [1:0] {
    DAPC_RUN,
    DAPC_FLUSH,
    DAPC_ENTER_SR,
    DAPC_SUSPENDED
  } dapc_pwr_type;

  dapc_pwr_type pwr;
  dapc_pwr_type next_pwr;
  dapc_addr_type xlat;
  logic clk_phase;

  // translation; single channel maps live elsewhere
  dapc_addr_map u_map (
    .geom(geom),
    .host_addr(req_addr),
    .mapped(xlat)
  );

  // requests stop while flushing so the pending set only shrinks
  assign req_ready = (pwr == DAPC_RUN) && !suspend_req && dual_symmetric;
  wire req_take = req_valid && req_ready;

  // translated request register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      map_valid <= 1'b0;
      map_write <= 1'b0;
      map_addr <= '0;
      map_rank <= '0;
    end else begin
      map_valid <= req_take;
      if (req_take) begin
        map_write <= req_write;
        map_addr <= xlat;
        map_rank <= req_rank;
      end
    end
  end

  // suspend sequence: drain, issue self refresh, then hold CKE low
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      DAPC_RUN: begin
        if (suspend_req) begin
          next_pwr = DAPC_FLUSH;
        end
      end
      DAPC_FLUSH: begin
        if (!pending && !map_valid) begin
          next_pwr = DAPC_ENTER_SR;
        end
      end
      DAPC_ENTER_SR: begin
        next_pwr = DAPC_SUSPENDED;
      end
      DAPC_SUSPENDED: begin
        if (!suspend_req) begin
          next_pwr = DAPC_RUN;
        end
      end
      default: begin
        next_pwr = DAPC_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwr <= DAPC_RUN;
    end else begin
      pwr <= next_pwr;
    end
  end

  // self refresh command is a single pulse to all populated ranks
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      self_refresh_cmd <= 1'b0;
      suspend_to_ram_state <= 1'b0;
    end else begin
      self_refresh_cmd <= (next_pwr == DAPC_ENTER_SR);
      suspend_to_ram_state <= (next_pwr == DAPC_SUSPENDED);
    end
  end

  // CKE low in suspend; empty ranks stay low always
  wire cke_on = (next_pwr == DAPC_RUN) || (next_pwr == DAPC_FLUSH);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cke <= '0;
    end else begin
      cke <= cke_on ? rank_present : '0;
    end
  end

  // ODT per rank: on writes terminate at the target rank; on reads at a
  // populated non-target rank of the same DIMM, never the driving one
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN*RANKS; g++) begin : g_odt
      localparam int CH = g / RANKS;
      localparam int RK = g % RANKS;
      wire on_chan = (map_addr.chan == CH[0]);
      wire target = on_chan && (map_rank == RK[$clog2(RANKS)-1:0]);
      wire want = xfer_active && on_chan && rank_present[g] &&
                  (map_write ? target : !target);
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          odt[g] <= 1'b0;
        end else begin
          odt[g] <= want && (pwr == DAPC_RUN ||
                             pwr == DAPC_FLUSH);
        end
      end
    end
  endgenerate

  // DIMM clocks: half sys_clk rate, all pairs in phase
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_phase <= 1'b0;
    end else begin
      clk_phase <= ~clk_phase;
    end
  end
  assign dimm_clk_p = {(NUM_CHAN*CLK_PAIRS){clk_phase}};
  assign dimm_clk_n = {(NUM_CHAN*CLK_PAIRS){~clk_phase}};

endmodule // dapc_ctl

// file: tb/dapc_dimm_model.sv
/*
  behavioural pair of DIMMs, two ranks each.
  assumes cke and odt come straight from dapc_ctl.
*/
`timescale 1ns/1ps
module dapc_dimm_model (
  // control from the block
  input wire logic [3:0] cke,
  input wire logic [3:0] odt,
  // rank state seen by the bench
  output logic [3:0] term_on,
  output logic [3:0] self_ref
);
  // dq, dm and strobes terminate only while odt is high
  assign term_on = odt;
  // a rank whose cke is low keeps refreshing itself
  assign self_ref = ~cke;
endmodule // dapc_dimm_model

// file: tb/dapc_ctl_sva.sv
/*
  assertions on the ports of dapc_ctl.
  assumes one clock domain and a bind into every dapc_ctl.
*/
`timescale 1ns/1ps
module dapc_ctl_sva #(
  parameter int CLK_PAIRS = 3,
  parameter int NUM_CHAN = 2,
  parameter int RANKS = 2
) (
  // clock, reset, config
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic dual_symmetric,
  // request and answer
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [dapc_pkg::DAPC_HOST_W-1:0] req_addr,
  input wire logic map_valid,
  input wire dapc_pkg::dapc_addr_type map_addr,
  // power and pins
  input wire logic pending,
  input wire logic self_refresh_cmd,
  input wire logic suspend_to_ram_state,
  input wire logic [NUM_CHAN*CLK_PAIRS-1:0] dimm_clk_p,
  input wire logic [NUM_CHAN*CLK_PAIRS-1:0] dimm_clk_n,
  input wire logic [NUM_CHAN*RANKS-1:0] cke
);
  import dapc_pkg::*;
  wire take = req_valid && req_ready;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // answer timing and refusal
  map_answer_a: assert property (take |=> map_valid)
    else $error("no answer");
  map_quiet_a: assert property (!take |=> !map_valid)
    else $error("stray answer");
  mode_refuse_a: assert property (!dual_symmetric |-> !req_ready)
    else $error("ready outside mode");
  // fields shared by every geometry
  chan_sel_a: assert property (
    take |=> map_addr.chan == $past(req_addr[6]))
    else $error("bad channel");
  col_low_a: assert property (
    take |=> map_addr.col[2:0] == $past(req_addr[5:3]))
    else $error("bad column");
  row_low_a: assert property (
    take |=> map_addr.row[10:0] == $past(req_addr[27:17]))
    else $error("bad row");
  // suspend entry waits for an empty pipe
  flush_first_a: assert property (
    self_refresh_cmd |-> !$past(pending))
    else $error("entry while pending");
  sr_enter_a: assert property (
    self_refresh_cmd |=> suspend_to_ram_state)
    else $error("no suspend state");
  cke_low_a: assert property (suspend_to_ram_state |-> cke == '0)
    else $error("cke high in suspend");
  clk_pair_a: assert property (dimm_clk_n == ~dimm_clk_p)
    else $error("clock pair skew");
  cover property (take ##1 take);
  cover property (self_refresh_cmd);
  cover property (suspend_to_ram_state ##1 !suspend_to_ram_state);
endmodule // dapc_ctl_sva
bind dapc_ctl dapc_ctl_sva #(.CLK_PAIRS(CLK_PAIRS), .NUM_CHAN(NUM_CHAN),
  .RANKS(RANKS)) u_sva (.*);

// file: tb/tb.sv
/*
  self-checking bench for dapc_ctl.
  assumes dapc_pkg, the dimm model and the checker compile first.
*/
`timescale 1ns/1ps
module tb;
  import dapc_pkg::*;
  logic sys_clk = 0, resetn = 0, dual_symmetric = 1, req_valid = 0;
  logic req_write = 0, pending = 0, xfer_active = 0, suspend_req = 0;
  logic req_ready, map_valid, map_write, self_refresh_cmd;
  logic suspend_to_ram_state;
  dapc_geom_type geom = DAPC_G256X8;
  logic [3:0] rank_present = 4'hf, cke, odt, term_on, self_ref;
  logic [32:0] req_addr = '0, prev;
  logic [0:0] req_rank = '0, map_rank;
  dapc_addr_type map_addr;
  dapc_addr_type want;
  logic [5:0] dimm_clk_p, dimm_clk_n;
  logic [31:0] seed = 32'hb30033f6;
  int errors = 0, samples_checked = 0, top;
  always #12.5 sys_clk = ~sys_clk;
  dapc_ctl u_dut (.*);
  dapc_dimm_model u_dimm (.*);
  // xorshift source, repeatable from the fixed seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // highest host bit that still lands in memory
  function automatic int top_of(dapc_geom_type g);
    case (g)
      DAPC_G256X16: return 27;
      DAPC_G256X8, DAPC_G512X16: return 28;
      DAPC_G1GX8: return 30;
      default: return 29;
    endcase
  endfunction
  // expected translation, worked out bit by bit
  function automatic dapc_addr_type exp_map(dapc_geom_type g,
                                            logic [32:0] a);
    dapc_addr_type m;
    logic b8, x16;
    b8 = (g == DAPC_G1GX8) || (g == DAPC_G1GX16);
    x16 = g == DAPC_G256X16;
    m = '0;
    m.chan = a[6];
    m.col = {x16 ? 1'b0 : a[13], a[12:7], a[5:3]};
    m.bank = b8 ? {a[14], a[15], a[16]} : {1'b0, x16 ? a[13] : a[15], a[14]};
    m.row[10:0] = a[27:17];
    m.row[11] = b8 ? a[29] : a[16];
    m.row[12] = x16 ? a[15] : a[28];
    m.row[13] = g == DAPC_G512X8 ? a[29] : g == DAPC_G1GX8 && a[30];
    m.out_of_range = |(a >> (top_of(g) + 1));
    return m;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs move a fixed 2 ns after the rising edge
  task tick();
    @(posedge sys_clk);
    #2;
  endtask
  task test_done();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    #2 resetn = 1;
    // back-to-back random requests, range edges among them
    for (int g = 0; g < 6; g++) begin
      geom = dapc_geom_type'(g);
      top = top_of(geom);
      for (int i = 0; i < 41; i++) begin
        // request inputs still stand, so they give the expectation
        if (i > 0) begin
          want = exp_map(geom, req_addr);
          chk(map_valid, 1);
          chk(map_addr, want);
          chk(map_addr.chan, want.chan);
          chk(map_addr.col, want.col);
          chk(map_addr.bank, want.bank);
          chk(map_addr.row, want.row);
          chk(map_addr.out_of_range, want.out_of_range);
          chk(map_write, req_write);
          chk(map_rank, req_rank);
        end
        req_valid = i < 40;
        prev = {1'b0, rnd()};
        req_write = prev[0];
        req_rank = prev[1:1];
        req_addr = {rnd(), seed[0]};
        if (i[0]) req_addr &= (33'h1 << (top + 1)) - 1;
        if (i == 2) req_addr = (33'h1 << (top + 1)) - 1;
        if (i == 4) req_addr = 33'h1 << (top + 1);
        tick();
      end
    end
    $display("test map done");
    // requests outside symmetric mode are refused
    dual_symmetric = 0;
    req_valid = 1;
    tick();
    chk(req_ready, 0);
    chk(map_valid, 0);
    dual_symmetric = 1;
    $display("test refuse done");
    // write then read to channel 1 rank 1
    for (int w = 1; w >= 0; w--) begin
      req_write = w[0];
      req_rank = 1'b1;
      req_addr = 33'h40;
      req_valid = 1;
      tick();
      req_valid = 0;
      xfer_active = 1;
      tick();
      chk(term_on, w ? 4'h8 : 4'h4);
      xfer_active = 0;
    end
    $display("test odt done");
    // suspend waits for pending work, then holds cke low
    pending = 1;
    suspend_req = 1;
    repeat (5) tick();
    chk(self_refresh_cmd | suspend_to_ram_state, 0);
    chk(req_ready, 0);
    pending = 0;
    for (int i = 0; i < 50 && suspend_to_ram_state !== 1'b1; i++) tick();
    if (suspend_to_ram_state !== 1'b1) begin
      errors++;
      test_done();
    end
    chk(cke, 0);
    chk(self_ref, 4'hf);
    rank_present = 4'h5;
    suspend_req = 0;
    repeat (2) tick();
    chk(cke, rank_present);
    $display("test suspend done");
    // six pairs, complementary, toggling
    prev = {27'h0, dimm_clk_p};
    tick();
    // xor keeps the expectation six bits wide inside the wider compare
    chk(dimm_clk_p, prev[5:0] ^ 6'h3f);
    chk(dimm_clk_n, dimm_clk_p ^ 6'h3f);
    $display("test clock done");
    test_done();
  end
endmodule // tb
